// ### include/safe_torque_off_pkg.sv
// Constants, register map and timing for the torque off input monitor
package safe_torque_off_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_COMM_FILTER = 6'h00;
  localparam logic [5:0] OFS_SAFETY_ENABLE = 6'h04;
  localparam logic [5:0] OFS_PW_ENTRY = 6'h08;
  localparam logic [5:0] OFS_PW_NEW = 6'h0C;
  localparam logic [5:0] OFS_PW_CONFIRM = 6'h10;
  localparam logic [5:0] OFS_TORQUE_STATUS = 6'h14;
  localparam logic [5:0] OFS_DISC_TOL = 6'h18;
  localparam logic [5:0] OFS_SAFE_DEBOUNCE = 6'h1C;
  localparam logic [5:0] OFS_STD_DEBOUNCE = 6'h20;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h24;
  localparam logic [5:0] OFS_IRQ_CLEAR = 6'h28;
  localparam logic [5:0] OFS_IRQ_ENABLE = 6'h2C;
  localparam logic [5:0] OFS_CONTROL = 6'h30;
  // Reset values
  localparam logic [7:0] RST_COMM_FILTER = 8'h00;
  localparam logic [3:0] RST_SAFETY_ENABLE = 4'h0;
  localparam logic [31:0] RST_PASSWORD = 32'h0000_0000;
  localparam logic [15:0] RST_DISC_TOL_MS = 16'h01F4;
  localparam logic [15:0] RST_SAFE_DEBOUNCE_MS = 16'h0001;
  localparam logic [15:0] RST_STD_DEBOUNCE_MS = 16'h0001;
  // Field codes
  localparam logic [7:0] COMM_SAFETY = 8'h5F;
  localparam logic [3:0] SFEN_NONE = 4'h0;
  localparam logic [3:0] SFEN_BASIC_TERMINALS = 4'h1;
  // Status and control bit positions
  localparam int STS_TORQUE_OFF = 1;
  localparam int STS_DISC_FAULT = 2;
  localparam int STS_TOGGLE_FAULT = 3;
  localparam int STS_UNLOCKED = 4;
  localparam int STS_COMMISSIONING = 5;
  localparam int CTRL_FAULT_ACK = 0;
  // Interrupt event bits
  localparam int IRQ_TORQUE_OFF = 0;
  localparam int IRQ_DISC_FAULT = 1;
  localparam int IRQ_TOGGLE_FAULT = 2;
  localparam int IRQ_N = 3;
  // Timing
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
  localparam int unsigned TOGGLE_LIMIT = 8;
  localparam int unsigned TOGGLE_WINDOW_MS = 100;
endpackage

// ### logic/safe_torque_off_input_monitor.sv
// Two-channel fail-safe input monitor selecting torque off
// Function
// - Safety settings change only while the entered password matches, new passwords must be nonzero, factory password is zero.
// - Safety settings are writable only while the commissioning filter holds 95.
// - Enable value 0 means no safety functions, 1 means basic functions from the terminals, reset 0.
// - Status bit 1 reads one while torque off is active.
// - Both fail-safe channels are compared continuously for equal level.
// - A disagreement lasting past the tolerance time raises a wiring fault, shorter ones are ignored.
// - Torque off is selected as soon as either filtered channel goes low, with no tolerance delay.
// - Pulses shorter than the debounce time are suppressed, so selection waits for that time.
// - Too many level changes on the fail-safe inputs within the monitoring interval raise a fault.
// - The standard input debounce and the fail-safe debounce are separate settings and paths.
// - While torque off is active, motor energy delivery is blocked.
`timescale 1ns/1ps
module safe_torque_off_input_monitor #(
  parameter int unsigned CYCLES_PER_MS = safe_torque_off_pkg::CYCLES_PER_MS,
  parameter int unsigned TOGGLE_LIMIT = safe_torque_off_pkg::TOGGLE_LIMIT,
  parameter int unsigned TOGGLE_WINDOW_MS = safe_torque_off_pkg::TOGGLE_WINDOW_MS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Input pins
  input wire logic fail_safe_input_a,
  input wire logic fail_safe_input_b,
  input wire logic standard_input,
  // Drive and status
  output logic motor_energy_enable,
  output logic torque_off_active_flag,
  output logic wiring_fault,
  output logic toggle_fault,
  output logic standard_input_filtered,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] comm;
    logic [3:0] sfen;
    logic [31:0] pw_entry;
    logic [31:0] pw_new;
    logic [31:0] pw_conf;
    logic [31:0] pw;
    logic [15:0] tol_ms;
    logic [15:0] sdb_ms;
    logic [15:0] stdb_ms;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] lv;
    logic [2:0] filt;
    logic [2:0][31:0] db_cnt;
    logic [31:0] pre;
    logic [15:0] disc_ms;
    logic [15:0] win_ms;
    logic [15:0] tog_cnt;
    logic disc_flt;
    logic tog_flt;
    logic torque_off;
    logic [safe_torque_off_pkg::IRQ_N-1:0] ists;
    logic [safe_torque_off_pkg::IRQ_N-1:0] ien;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [31:0] thr_safe;
  logic [31:0] thr_std;
  logic unlocked;
  logic setting_ok;
  logic wr_go;
  logic ms_tick;
  logic enabled;
  localparam int IRQ_EV_W = safe_torque_off_pkg::IRQ_N;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Thresholds in cycles; the standard path never sees the safe setting
  assign thr_safe = 32'(32'(st_r.sdb_ms) * CYCLES_PER_MS);
  assign thr_std = 32'(32'(st_r.stdb_ms) * CYCLES_PER_MS);
  assign unlocked = (st_r.pw_entry == st_r.pw);
  assign setting_ok = unlocked && (st_r.comm == safe_torque_off_pkg::COMM_SAFETY);
  assign wr_go = write && st_r.ack;
  assign ms_tick = (st_r.pre == 32'(CYCLES_PER_MS - 1));
  assign enabled = (st_r.sfen == safe_torque_off_pkg::SFEN_BASIC_TERMINALS);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] wd;
    logic [31:0] rv;
    logic [31:0] thr;
    logic [2:0] chg;
    logic [IRQ_EV_W-1:0] ev;
    logic [15:0] add;
    st_nxt = st_r;
    wd = 32'h0000_0000;
    rv = 32'h0000_0000;
    thr = 32'h0000_0000;
    chg = 3'h0;
    ev = '0;
    add = 16'h0000;

    // Bus: one wait cycle, then answer; write lands on the answering edge
    st_nxt.ack = (read || write) && !st_r.ack;
    case (address)
      safe_torque_off_pkg::OFS_COMM_FILTER: rv = {24'h000000, st_r.comm};
      safe_torque_off_pkg::OFS_SAFETY_ENABLE: rv = {28'h0000000, st_r.sfen};
      safe_torque_off_pkg::OFS_PW_ENTRY: rv = st_r.pw_entry;
      safe_torque_off_pkg::OFS_PW_NEW: rv = st_r.pw_new;
      safe_torque_off_pkg::OFS_PW_CONFIRM: rv = st_r.pw_conf;
      safe_torque_off_pkg::OFS_TORQUE_STATUS: begin
        rv[safe_torque_off_pkg::STS_TORQUE_OFF] = st_r.torque_off;
        rv[safe_torque_off_pkg::STS_DISC_FAULT] = st_r.disc_flt;
        rv[safe_torque_off_pkg::STS_TOGGLE_FAULT] = st_r.tog_flt;
        rv[safe_torque_off_pkg::STS_UNLOCKED] = unlocked;
        rv[safe_torque_off_pkg::STS_COMMISSIONING] =
          (st_r.comm == safe_torque_off_pkg::COMM_SAFETY);
      end
      safe_torque_off_pkg::OFS_DISC_TOL: rv = {16'h0000, st_r.tol_ms};
      safe_torque_off_pkg::OFS_SAFE_DEBOUNCE: rv = {16'h0000, st_r.sdb_ms};
      safe_torque_off_pkg::OFS_STD_DEBOUNCE: rv = {16'h0000, st_r.stdb_ms};
      safe_torque_off_pkg::OFS_IRQ_STATUS: rv = 32'(st_r.ists);
      safe_torque_off_pkg::OFS_IRQ_ENABLE: rv = 32'(st_r.ien);
      default: rv = 32'h0000_0000;
    endcase
    if (read && !st_r.ack) begin
      st_nxt.rdata = rv;
    end

    if (wr_go) begin
      wd = merge(rv, writedata, byteenable);
      case (address)
        safe_torque_off_pkg::OFS_COMM_FILTER: st_nxt.comm = wd[7:0];
        safe_torque_off_pkg::OFS_SAFETY_ENABLE: begin
          if (setting_ok) begin
            st_nxt.sfen = wd[3:0];
          end
        end
        safe_torque_off_pkg::OFS_PW_ENTRY: st_nxt.pw_entry = wd;
        safe_torque_off_pkg::OFS_PW_NEW: st_nxt.pw_new = wd;
        safe_torque_off_pkg::OFS_PW_CONFIRM: begin
          st_nxt.pw_conf = wd;
          // A rejected password leaves the old one in force
          if (unlocked && wd == st_r.pw_new && wd != 32'h0000_0000) begin
            st_nxt.pw = wd;
            st_nxt.pw_entry = wd;
          end
        end
        safe_torque_off_pkg::OFS_DISC_TOL: begin
          if (setting_ok) begin
            st_nxt.tol_ms = wd[15:0];
          end
        end
        safe_torque_off_pkg::OFS_SAFE_DEBOUNCE: begin
          if (setting_ok) begin
            st_nxt.sdb_ms = wd[15:0];
          end
        end
        safe_torque_off_pkg::OFS_STD_DEBOUNCE: st_nxt.stdb_ms = wd[15:0];
        safe_torque_off_pkg::OFS_IRQ_ENABLE: st_nxt.ien = wd[IRQ_EV_W-1:0];
        default: st_nxt.comm = st_nxt.comm;
      endcase
    end

    // Pins: two flops before anything looks at them
    st_nxt.s1 = {standard_input, fail_safe_input_b, fail_safe_input_a};
    st_nxt.s2 = st_r.s1;
    st_nxt.lv = st_r.s2;
    st_nxt.pre = ms_tick ? 32'h0000_0000 : st_r.pre + 32'h0000_0001;

    // Debounce: level passes only after staying put for the set time
    for (int c = 0; c < 3; c++) begin
      thr = (c == 2) ? thr_std : thr_safe;
      if (st_r.s2[c] == st_r.filt[c]) begin
        st_nxt.db_cnt[c] = 32'h0000_0000;
      end else if (st_r.db_cnt[c] >= thr) begin
        st_nxt.filt[c] = st_r.s2[c];
        st_nxt.db_cnt[c] = 32'h0000_0000;
      end else begin
        st_nxt.db_cnt[c] = st_r.db_cnt[c] + 32'h0000_0001;
      end
    end

    // Simultaneity check on the filtered channels
    if (st_r.filt[0] == st_r.filt[1]) begin
      st_nxt.disc_ms = 16'h0000;
    end else begin
      if (st_r.disc_ms >= st_r.tol_ms) begin
        st_nxt.disc_flt = 1'b1;
      end else if (ms_tick) begin
        st_nxt.disc_ms = st_r.disc_ms + 16'h0001;
      end
    end

    // Toggle count over a fixed window; raw edges so test pulses count too
    chg = st_r.s2 ^ st_r.lv;
    add = 16'(chg[0]) + 16'(chg[1]);
    if (ms_tick && st_r.win_ms >= 16'(TOGGLE_WINDOW_MS - 1)) begin
      st_nxt.win_ms = 16'h0000;
      st_nxt.tog_cnt = add;
    end else begin
      st_nxt.win_ms = ms_tick ? st_r.win_ms + 16'h0001 : st_r.win_ms;
      st_nxt.tog_cnt = (st_r.tog_cnt > 16'hFFF0) ? st_r.tog_cnt : st_r.tog_cnt + add;
    end
    if (st_r.tog_cnt > 16'(TOGGLE_LIMIT)) begin
      st_nxt.tog_flt = 1'b1;
    end

    // Fault acknowledge; a fault still present sets again and wins
    if (wr_go && address == safe_torque_off_pkg::OFS_CONTROL &&
        byteenable[0] && writedata[safe_torque_off_pkg::CTRL_FAULT_ACK]) begin
      st_nxt.disc_flt = (st_r.filt[0] != st_r.filt[1]) && (st_r.disc_ms >= st_r.tol_ms);
      st_nxt.tog_flt = st_r.tog_cnt > 16'(TOGGLE_LIMIT);
    end

    // Either channel low selects at once; faults also hold torque off
    st_nxt.torque_off = enabled && (!st_r.filt[0] || !st_r.filt[1] ||
                             st_r.disc_flt || st_r.tog_flt);

    // Sticky events, set beats clear
    ev[safe_torque_off_pkg::IRQ_TORQUE_OFF] = st_nxt.torque_off && !st_r.torque_off;
    ev[safe_torque_off_pkg::IRQ_DISC_FAULT] = st_nxt.disc_flt && !st_r.disc_flt;
    ev[safe_torque_off_pkg::IRQ_TOGGLE_FAULT] = st_nxt.tog_flt && !st_r.tog_flt;
    if (wr_go && address == safe_torque_off_pkg::OFS_IRQ_CLEAR) begin
      st_nxt.ists = st_r.ists & ~writedata[IRQ_EV_W-1:0];
    end
    st_nxt.ists = st_nxt.ists | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.comm <= safe_torque_off_pkg::RST_COMM_FILTER;
      st_r.sfen <= safe_torque_off_pkg::RST_SAFETY_ENABLE;
      st_r.pw <= safe_torque_off_pkg::RST_PASSWORD;
      st_r.pw_entry <= safe_torque_off_pkg::RST_PASSWORD;
      st_r.tol_ms <= safe_torque_off_pkg::RST_DISC_TOL_MS;
      st_r.sdb_ms <= safe_torque_off_pkg::RST_SAFE_DEBOUNCE_MS;
      st_r.stdb_ms <= safe_torque_off_pkg::RST_STD_DEBOUNCE_MS;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign readdata = st_r.rdata;
  assign waitrequest = (read || write) && !st_r.ack;
  assign motor_energy_enable = !st_r.torque_off;
  assign torque_off_active_flag = st_r.torque_off;
  assign wiring_fault = st_r.disc_flt;
  assign toggle_fault = st_r.tog_flt;
  assign standard_input_filtered = st_r.filt[2];
  assign irq = |(st_r.ists & st_r.ien);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_pw_lock_enable: assert property (
    (wr_go && address == safe_torque_off_pkg::OFS_SAFETY_ENABLE && !unlocked)
    |=> $stable(st_r.sfen)) else $error("enable changed while locked");
  a_comm_gate_tol: assert property (
    (wr_go && address == safe_torque_off_pkg::OFS_DISC_TOL &&
     st_r.comm != safe_torque_off_pkg::COMM_SAFETY)
    |=> $stable(st_r.tol_ms)) else $error("tolerance changed outside commissioning");
  a_disabled_no_sto: assert property (
    (st_r.sfen == safe_torque_off_pkg::SFEN_NONE) |=> !st_r.torque_off)
    else $error("torque off while safety disabled");
  a_status_bit_read: assert property (
    (read && !st_r.ack && address == safe_torque_off_pkg::OFS_TORQUE_STATUS)
    |=> !waitrequest && readdata[safe_torque_off_pkg::STS_TORQUE_OFF] == $past(st_r.torque_off))
    else $error("status bit does not show torque off");
  a_chan_agree_clear: assert property (
    (st_r.filt[0] == st_r.filt[1]) |=> st_r.disc_ms == 16'h0000)
    else $error("discrepancy timer ran while channels agree");
  a_disc_fault_set: assert property (
    (st_r.filt[0] != st_r.filt[1] && st_r.disc_ms >= st_r.tol_ms) |=> st_r.disc_flt)
    else $error("wiring fault not raised");
  a_low_selects_now: assert property (
    (enabled && !st_r.filt[0] && !(wr_go && address == safe_torque_off_pkg::OFS_SAFETY_ENABLE))
    |=> st_r.torque_off) else $error("torque off delayed after low channel");
  a_short_pulse_held: assert property (
    (st_r.s2[0] != st_r.filt[0] && st_r.db_cnt[0] < thr_safe) |=> $stable(st_r.filt[0]))
    else $error("pulse passed before debounce time");
  a_toggle_fault_set: assert property (
    (st_r.tog_cnt > 16'(TOGGLE_LIMIT)) |=> st_r.tog_flt)
    else $error("toggle fault not raised");
  a_std_path_own: assert property (
    (st_r.s2[2] != st_r.filt[2] && st_r.db_cnt[2] < thr_std) |=> $stable(st_r.filt[2]))
    else $error("standard input passed early");
  a_sto_no_energy: assert property (
    $rose(st_r.torque_off) |-> !motor_energy_enable ##1 (!motor_energy_enable || !$past(st_r.torque_off)))
    else $error("energy delivered during torque off");

  c_sto_select: cover property ($rose(st_r.torque_off));
  c_wiring_fault: cover property ($rose(st_r.disc_flt));
  c_toggle_fault: cover property ($rose(st_r.tog_flt));
  c_pw_change: cover property ($changed(st_r.pw));
endmodule

// ### dv/stop_sensor_model.sv
// Dual-channel safety sensor model driving the two fail-safe channels
`timescale 1ns/1ps
module stop_sensor_model (
  // Clock
  input wire logic clock,
  // Contact channels
  output logic chan_a,
  output logic chan_b
);
  initial begin
    chan_a = 1'b1;
    chan_b = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Steady contact levels, changed just after an edge
  task automatic set_levels(input logic a, input logic b);
    @(posedge clock);
    chan_a <= a;
    chan_b <= b;
  endtask
  // Dark test pulse, kept short so the input filter can hide it
  task automatic dark_pulse(input logic on_b, input int len);
    @(posedge clock);
    if (on_b) chan_b <= 1'b0; else chan_a <= 1'b0;
    repeat (len) @(posedge clock);
    if (on_b) chan_b <= 1'b1; else chan_a <= 1'b1;
  endtask
endmodule

// ### dv/safe_torque_off_input_monitor_tb_top.sv
// Register-level testbench for the torque off input monitor
`timescale 1ns/1ps
module safe_torque_off_input_monitor_tb_top;
  // Short millisecond keeps the run brief
  localparam int CPM = 10;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, chan_a, chan_b, motor_on, flag, wfault, tfault, std_filt, irq;
  logic standard_input = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  stop_sensor_model i_stop_sensor_model (.clock(clock), .chan_a(chan_a), .chan_b(chan_b));
  safe_torque_off_input_monitor #(.CYCLES_PER_MS(CPM)) i_safe_torque_off_input_monitor (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .fail_safe_input_a(chan_a), .fail_safe_input_b(chan_b),
    .standard_input(standard_input), .motor_energy_enable(motor_on),
    .torque_off_active_flag(flag), .wiring_fault(wfault), .toggle_fault(tfault),
    .standard_input_filtered(std_filt), .irq(irq));
  initial begin
    forever #25 clock = ~clock;
  end
  // Hang guard, well above the planned run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_mismatch++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Held until waitrequest is seen low at a rising edge; data taken and request dropped there
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask
  task automatic pins(input logic [3:0] e, input string m);
    chk({28'h0, flag, motor_on, wfault, irq}, {28'h0, e}, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd_chk(safe_torque_off_pkg::OFS_PW_ENTRY, 32'h0, "pw reset");
    rd_chk(safe_torque_off_pkg::OFS_SAFETY_ENABLE, 32'h0, "enable reset");
    rd_chk(safe_torque_off_pkg::OFS_DISC_TOL, 32'h1F4, "tol reset");
    rd_chk(safe_torque_off_pkg::OFS_SAFE_DEBOUNCE, 32'h1, "debounce reset");
    rd_chk(6'h3C, 32'h0, "unmapped");
    wr(safe_torque_off_pkg::OFS_SAFETY_ENABLE, 32'h1);
    rd_chk(safe_torque_off_pkg::OFS_SAFETY_ENABLE, 32'h0, "not commissioning");
    wr(safe_torque_off_pkg::OFS_COMM_FILTER, 32'h5F);
    wr(safe_torque_off_pkg::OFS_PW_NEW, 32'h5);
    wr(safe_torque_off_pkg::OFS_PW_CONFIRM, 32'h5);
    wr(safe_torque_off_pkg::OFS_PW_ENTRY, 32'h7);
    wr(safe_torque_off_pkg::OFS_DISC_TOL, 32'h2);
    rd_chk(safe_torque_off_pkg::OFS_DISC_TOL, 32'h1F4, "wrong password");
    wr(safe_torque_off_pkg::OFS_PW_ENTRY, 32'h5);
    wr(safe_torque_off_pkg::OFS_PW_NEW, 32'h0);
    wr(safe_torque_off_pkg::OFS_PW_CONFIRM, 32'h0);
    wr(safe_torque_off_pkg::OFS_DISC_TOL, 32'h2);
    rd_chk(safe_torque_off_pkg::OFS_DISC_TOL, 32'h2, "right password");
    wr(safe_torque_off_pkg::OFS_SAFETY_ENABLE, 32'h1);
    rd_chk(safe_torque_off_pkg::OFS_SAFETY_ENABLE, 32'h1, "enable basic");
    wr(safe_torque_off_pkg::OFS_IRQ_CLEAR, 32'h7);
    wr(safe_torque_off_pkg::OFS_IRQ_ENABLE, 32'h7);
    cyc(5);
    pins(4'b0100, "idle run");
    $display("test setup done");
    i_stop_sensor_model.dark_pulse(1'b0, 5);
    cyc(30);
    pins(4'b0100, "short pulse");
    rd_chk(safe_torque_off_pkg::OFS_IRQ_STATUS, 32'h0, "pulse no event");
    $display("test pulse done");
    i_stop_sensor_model.set_levels(1'b0, 1'b1);
    cyc(8);
    pins(4'b0100, "inside debounce");
    cyc(12);
    pins(4'b1001, "torque off");
    cyc(50);
    pins(4'b1011, "wiring fault");
    rd_chk(safe_torque_off_pkg::OFS_TORQUE_STATUS, 32'h36, "status word");
    rd_chk(safe_torque_off_pkg::OFS_IRQ_STATUS, 32'h3, "events");
    wr(safe_torque_off_pkg::OFS_IRQ_ENABLE, 32'h0);
    cyc(1);
    pins(4'b1010, "masked");
    wr(safe_torque_off_pkg::OFS_IRQ_ENABLE, 32'h7);
    wr(safe_torque_off_pkg::OFS_IRQ_CLEAR, 32'h7);
    cyc(1);
    pins(4'b1010, "cleared");
    i_stop_sensor_model.set_levels(1'b1, 1'b1);
    cyc(30);
    wr(safe_torque_off_pkg::OFS_CONTROL, 32'h1);
    cyc(5);
    pins(4'b0100, "acknowledged");
    $display("test discrepancy done");
    // Enough edges that any window split still exceeds the limit
    for (int i = 0; i < 9; i++) begin
      i_stop_sensor_model.dark_pulse(1'b1, 2);
    end
    cyc(10);
    chk({30'h0, tfault, flag}, 32'h3, "toggle fault");
    cyc(2100);
    wr(safe_torque_off_pkg::OFS_CONTROL, 32'h1);
    cyc(5);
    chk({30'h0, tfault, flag}, 32'h0, "toggle cleared");
    $display("test toggle done");
    wr(safe_torque_off_pkg::OFS_STD_DEBOUNCE, 32'h5);
    standard_input <= 1'b1;
    cyc(30);
    chk({31'h0, std_filt}, 32'h0, "std slow");
    cyc(50);
    chk({31'h0, std_filt}, 32'h1, "std passes");
    rd_chk(safe_torque_off_pkg::OFS_SAFE_DEBOUNCE, 32'h1, "safe untouched");
    $display("test standard input done");
    wr(safe_torque_off_pkg::OFS_SAFETY_ENABLE, 32'h2);
    i_stop_sensor_model.set_levels(1'b0, 1'b0);
    cyc(40);
    chk({31'h0, flag}, 32'h0, "safety disabled");
    $display("test disable done");
    summarize();
  end
endmodule
